/* File: tb/pin_observer.sv */
// equipment on the output terminals: counts pwm pulses
`timescale 1ns/1ps
module pin_observer (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic pwm_i,
  output int pulses_o
);
  logic last, next_last;
  int next_pulses;
  // rising pwm edges since the last clear
  always_comb begin
    next_last = pwm_i;
    next_pulses = clr_i ? 0 : pulses_o + ((pwm_i && !last) ? 1 : 0);
  end
  always_ff @(posedge clk_i) begin
    last <= next_last;
    pulses_o <= next_pulses;
  end
endmodule : pin_observer

/* File: tb/pwm_compare_properties.sv */
// concurrent checks on the ports of the pulse burst and compare block
`timescale 1ns/1ps
`include "pwm_compare_cfg.svh"
module pwm_compare_properties (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic PWM_O,
  input wire logic MATCH_OUTPUT_PIN_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic wr, rd, wr_ctl, want, next_want;
  logic [1:0] hold, next_hold;
  // address and data taken together, read address taken
  assign wr = CE_I && AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  assign rd = CE_I && ARVALID_I && ARREADY_O;
  assign wr_ctl = wr && AWADDR_I == `OFS_CONTROL && WSTRB_I[3];
  // expected forced pin level, settled three cycles after the write
  always_comb begin
    next_hold = hold;
    next_want = want;
    if (wr_ctl) begin
      next_hold = WDATA_I[26] ? 2'h1 : 2'h0;
      next_want = WDATA_I[27] ^ WDATA_I[25];
    end else if (hold != 2'h0 && hold != 2'h3) begin
      next_hold = hold + 2'h1;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      hold <= 2'h0;
      want <= 1'b0;
    end else begin
      hold <= next_hold;
      want <= next_want;
    end
  end
  a_write_answer: assert property (wr |=> BVALID_O)
    else $error("write response missing");
  a_bvalid_clears: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write response not withdrawn");
  a_write_blocked: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken while response pending");
  a_read_answer: assert property (rd |=> RVALID_O)
    else $error("read response missing");
  a_rvalid_clears: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read response not withdrawn");
  a_read_blocked: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken while response pending");
  a_unmapped_read: assert property (rd && ARADDR_I > `OFS_PWM_SETUP
    |=> RRESP_O == `RESP_SLVERR && RDATA_O == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_flush_reads_zero: assert property (
    rd && ARADDR_I == `OFS_CONTROL |=> !RDATA_O[30])
    else $error("flush bit read as one");
  a_zero_count_quiet: assert property (
    wr && AWADDR_I == `OFS_BURST_COUNT && WSTRB_I[2:1] == 2'h3
    && WDATA_I[19:8] == 12'h000 |-> ##4 (!PWM_O) [*8])
    else $error("pulse after zero count");
  a_forced_pin: assert property (
    hold == 2'h3 |-> MATCH_OUTPUT_PIN_O == want)
    else $error("forced pin level wrong");
  c_write_done: cover property (BVALID_O && BREADY_I);
  c_pwm_pulse: cover property ($rose(PWM_O));
  c_pin_high: cover property ($rose(MATCH_OUTPUT_PIN_O));
endmodule : pwm_compare_properties

bind pwm_burst_and_position_compare pwm_compare_properties
  i_pwm_compare_properties (.MCLK_I, .SYS_RST_I, .CE_I, .AWADDR_I,
  .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O,
  .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O,
  .RRESP_O, .RVALID_O, .RREADY_I, .PWM_O, .MATCH_OUTPUT_PIN_O);

/* File: tb/test_pwm_burst_and_position_compare.sv */
// self-checking bench for the pulse burst and compare block
`timescale 1ns/1ps
`include "pwm_compare_cfg.svh"
module test_pwm_burst_and_position_compare;
  logic MCLK_I = 1'b0, SYS_RST_I = 1'b1, clr = 1'b1;
  logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic PHASE_CLK_I = 1'b0, SERVO_CLK_I = 1'b0;
  logic [7:0] AWADDR_I = 8'h00, ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0000_0000;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic PWM_O, MATCH_OUTPUT_PIN_O;
  logic [1:0] BRESP_O, RRESP_O, resp;
  logic [31:0] RDATA_O, rdat;
  int pulses, bad_count = 0, checks = 0, cycles = 0;

  pwm_burst_and_position_compare i_pwm_burst_and_position_compare (
    .MCLK_I, .SYS_RST_I, .CE_I(1'b1), .AWADDR_I, .AWVALID_I, .AWREADY_O,
    .WDATA_I, .WSTRB_I(4'hF), .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
    .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
    .RVALID_O, .RREADY_I, .PHASE_CLK_I, .SERVO_CLK_I, .PWM_O,
    .MATCH_OUTPUT_PIN_O);
  pin_observer i_pin_observer (.clk_i(MCLK_I), .clr_i(clr), .pwm_i(PWM_O),
    .pulses_o(pulses));

  // 200 MHz clock and hang guard
  always #2.5 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  task automatic summarize;
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one write; outputs judged at the falling edge before each sample
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge MCLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge MCLK_I);
      ta = AWVALID_I && AWREADY_O;
      tw = WVALID_I && WREADY_O;
      tb = BVALID_O;
      resp = BRESP_O;
      @(posedge MCLK_I);
      if (ta) AWVALID_I <= 1'b0;
      if (tw) WVALID_I <= 1'b0;
    end
    BREADY_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge MCLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge MCLK_I);
      ta = ARVALID_I && ARREADY_O;
      tr = RVALID_O;
      rdat = RDATA_O;
      resp = RRESP_O;
      @(posedge MCLK_I);
      if (ta) ARVALID_I <= 1'b0;
    end
    RREADY_I <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge MCLK_I);
    @(negedge MCLK_I);
  endtask : idle

  task automatic zero_count;
    @(posedge MCLK_I);
    clr <= 1'b1;
    @(posedge MCLK_I);
    clr <= 1'b0;
  endtask : zero_count

  // one rising edge of the phase (ph=1) or servo interpolation clock
  task automatic tick(input logic ph);
    @(posedge MCLK_I);
    if (ph) PHASE_CLK_I <= 1'b1;
    else SERVO_CLK_I <= 1'b1;
    repeat (3) @(posedge MCLK_I);
    PHASE_CLK_I <= 1'b0;
    SERVO_CLK_I <= 1'b0;
    // phase period 820 ns keeps lag step 3 legal
    repeat (ph ? 160 : 4) @(posedge MCLK_I);
  endtask : tick

  task automatic t_registers;
    rdchk(`OFS_START_DELAY, 32'h0000_0000);
    rdchk(`OFS_BURST_COUNT, 32'h0000_0000);
    rdchk(`OFS_TABLE_PORT, 32'h0000_0000);
    rdchk(`OFS_CONTROL, 32'h0000_0000);
    wr(`OFS_START_DELAY, 32'hFFE1_FF00);
    rdchk(`OFS_START_DELAY, 32'hFFE1_FF00);
    rd(8'h1C);
    chk(resp, `RESP_SLVERR);
    wr(8'h1C, 32'h1234_5678);
    chk(resp, `RESP_SLVERR);
  endtask : t_registers

  // lag 3, delay 5: start 80 cycles after the servo edge, period 40
  task automatic t_burst;
    wr(`OFS_START_DELAY, 32'h0030_0500);
    wr(`OFS_BURST_COUNT, 32'h0000_0200);
    zero_count();
    idle(30);
    chk(pulses, 0);
    tick(1'b0);
    idle(73);
    chk(pulses, 0);
    idle(2);
    chk(pulses, 1);
    idle(300);
    chk(pulses, 2);
    rdchk(`OFS_BURST_COUNT, 32'h0000_0000);
  endtask : t_burst

  // period 20 on the phase clock: 25 pulses by the end of the wait
  task automatic t_endless;
    wr(`OFS_PWM_SETUP, 32'h0014_0001);
    rdchk(`OFS_PWM_SETUP, 32'h0014_0001);
    wr(`OFS_BURST_COUNT, 32'h000F_FF00);
    zero_count();
    tick(1'b1);
    idle(400);
    chk(pulses, 25);
    rdchk(`OFS_BURST_COUNT, 32'h000F_FF00);
    chk(pulses >= 5, 1);
    wr(`OFS_BURST_COUNT, 32'h0000_0000);
    idle(10);
    zero_count();
    idle(200);
    chk(pulses, 0);
  endtask : t_endless

  // entries 10, 20, 30, travel 4 per phase edge
  task automatic t_compare;
    wr(`OFS_CONTROL, 32'h4000_0000);
    rdchk(`OFS_CONTROL, 32'h0000_0000);
    wr(`OFS_TABLE_PORT, 32'h0000_000A);
    wr(`OFS_TABLE_PORT, 32'h0000_0014);
    wr(`OFS_TABLE_PORT, 32'h0000_001E);
    rdchk(`OFS_TABLE_PORT, 32'h0000_000A);
    wr(`OFS_STEP_DIST, 32'h0000_0004);
    wr(`OFS_CONTROL, 32'hA000_0000);
    for (int i = 0; i < 3; i++) tick(1'b0);
    rdchk(`OFS_TABLE_PORT, 32'h0000_000A);
    tick(1'b1);
    tick(1'b1);
    idle(1);
    chk(MATCH_OUTPUT_PIN_O, 1'b0);
    tick(1'b1);
    idle(1);
    chk(MATCH_OUTPUT_PIN_O, 1'b1);
    rdchk(`OFS_TABLE_PORT, 32'h0000_0014);
    wr(`OFS_CONTROL, 32'hA400_0000);
    idle(3);
    chk(MATCH_OUTPUT_PIN_O, 1'b0);
    wr(`OFS_CONTROL, 32'hAC00_0000);
    idle(3);
    chk(MATCH_OUTPUT_PIN_O, 1'b1);
    wr(`OFS_CONTROL, 32'hA200_0000);
    idle(3);
    chk(MATCH_OUTPUT_PIN_O, 1'b0);
    wr(`OFS_CONTROL, 32'h0000_0000);
    rdchk(`OFS_TABLE_PORT, 32'h0000_000A);
    for (int i = 0; i < 3; i++) tick(1'b1);
    idle(1);
    chk(MATCH_OUTPUT_PIN_O, 1'b1);
  endtask : t_compare

  initial begin
    repeat (2) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    clr <= 1'b0;
    t_registers();
    t_burst();
    t_endless();
    t_compare();
    summarize();
  end
endmodule : test_pwm_burst_and_position_compare

/* File: verilog/compare_table_mem.sv */
// comparison table storage with registered read port
`timescale 1ns/1ps
module compare_table_mem (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [11:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [11:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:4095];

  // write port and registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : compare_table_mem

/* File: verilog/pwm_burst_and_position_compare.sv */
// top: axi4-lite registers, pwm burst and position compare output
//
// Summary of operation
// (R1) lag step scales delay, 10 ns units
// (R2) burst starts after (delay+3) lag units
// (R3) software keeps lag step below phase limit
// (R4) software writes zero to reserved bits
// (R5) each emitted pulse decrements the count
// (R6) count reads remaining; zero means no pulses
// (R7) maximum count runs pulses forever, undecremented
// (R8) host writes step travel every interpolation cycle
// (R9) table writes append the next entry
// (R10) table read returns entry under comparison
// (R11) run bit starts and stops comparison
// (R12) flush bit clears table, reads zero
// (R13) software stops comparison before a flush
// (R14) interp choice: servo at 0, phase at 1
// (R15) interp choice changed only while stopped
// (R16) force field forces or releases output
// (R17) invert bit flips the pin level
// (R18) accumulate travel, match entry, advance pointer
`timescale 1ns/1ps
`include "pwm_compare_cfg.svh"
module pwm_burst_and_position_compare
  import pwm_compare_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic PHASE_CLK_I,
  input wire logic SERVO_CLK_I,
  output logic PWM_O,
  output logic MATCH_OUTPUT_PIN_O
);
  // bus slave state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic [1:0] bresp, next_bresp;
  logic bvalid, next_bvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic rvalid, next_rvalid;
  logic do_write;
  // register contents
  logic [31:0] start_delay, next_start_delay;
  logic [31:0] step_travel, next_step_travel;
  logic [15:0] pwm_period, next_pwm_period;
  logic pwm_clock_choice, next_pwm_clock_choice;
  match_ctrl_t ctrl, next_ctrl;
  // compare state
  logic [11:0] wr_ptr, next_wr_ptr;
  logic [11:0] cmp_ptr, next_cmp_ptr;
  logic [31:0] position, next_position;
  logic match_state, next_match_state;
  logic check, next_check;
  logic phase_prev, servo_prev;
  logic [31:0] table_entry_value;
  logic table_we;
  logic burst_load;
  logic [11:0] burst_remaining;
  logic pwm_edge, interp_edge, compare_out;
  pwm_setup_t pwm_setup;

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // rising edges of the controller clocks, sampled as plain inputs
  assign pwm_edge = pwm_clock_choice ? (PHASE_CLK_I & ~phase_prev)
                                     : (SERVO_CLK_I & ~servo_prev);
  assign interp_edge = ctrl.interp_clock_choice ?
                       (PHASE_CLK_I & ~phase_prev) :
                       (SERVO_CLK_I & ~servo_prev); // R14

  // handshake outputs
  assign AWREADY_O = ~aw_held & ~bvalid;
  assign WREADY_O = ~w_held & ~bvalid;
  assign ARREADY_O = ~rvalid;
  assign BVALID_O = bvalid;
  assign BRESP_O = bresp;
  assign RVALID_O = rvalid;
  assign RRESP_O = rresp;
  assign RDATA_O = rdata;
  // both halves held or taken now; current state only, no loop
  assign do_write = (aw_held | (AWVALID_I & AWREADY_O)) &
                    (w_held | (WVALID_I & WREADY_O)) & ~bvalid;

  // write and read channels
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bresp = bresp;
    next_bvalid = bvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rvalid = rvalid;
    if (AWVALID_I && AWREADY_O) begin
      next_aw_held = 1'b1;
      next_waddr = AWADDR_I;
    end
    if (WVALID_I && WREADY_O) begin
      next_w_held = 1'b1;
      next_wdata = WDATA_I;
      next_wstrb = WSTRB_I;
    end
    if (bvalid && BREADY_I) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (next_waddr)
        `OFS_START_DELAY, `OFS_BURST_COUNT, `OFS_STEP_DIST,
        `OFS_TABLE_PORT, `OFS_CONTROL, `OFS_PWM_SETUP: begin
          next_bresp = `RESP_OKAY;
        end
        default: begin
          next_bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && RREADY_I) begin
      next_rvalid = 1'b0;
    end
    if (ARVALID_I && ARREADY_O) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000; // R4
      case (ARADDR_I)
        `OFS_START_DELAY: begin
          next_rdata[`LAG_HI:`LAG_LO] = start_delay[`LAG_HI:`LAG_LO];
          next_rdata[`DELAY_HI:`DELAY_LO] =
            start_delay[`DELAY_HI:`DELAY_LO];
        end
        `OFS_BURST_COUNT: begin
          next_rdata[`COUNT_HI:`COUNT_LO] = burst_remaining; // R6
        end
        `OFS_STEP_DIST: begin
        end
        `OFS_TABLE_PORT: begin
          // an empty table reads as the reset value
          if (cmp_ptr != wr_ptr) begin
            next_rdata = table_entry_value; // R10
          end
        end
        `OFS_CONTROL: begin
          next_rdata[`RUN_BIT] = ctrl.match_run;
          next_rdata[`FLUSH_BIT] = 1'b0; // R12
          next_rdata[`INTERP_BIT] = ctrl.interp_clock_choice;
          next_rdata[`FORCE_HI:`FORCE_LO] = ctrl.match_force_field;
          next_rdata[`INVERT_BIT] = ctrl.match_pin_invert;
        end
        `OFS_STATUS: begin
          next_rdata[`STAT_OUT_BIT] = MATCH_OUTPUT_PIN_O;
          next_rdata[`STAT_WP_HI:`STAT_WP_LO] = wr_ptr;
          next_rdata[`STAT_CP_HI:`STAT_CP_LO] = cmp_ptr;
        end
        `OFS_PWM_SETUP: begin
          next_rdata[`SETUP_PER_HI:`SETUP_PER_LO] = pwm_period;
          next_rdata[`SETUP_CHOICE_BIT] = pwm_clock_choice;
        end
        default: begin
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  // register writes and their side effects
  always_comb begin
    logic [31:0] wval;
    wval = 32'h0000_0000;
    next_start_delay = start_delay;
    next_step_travel = step_travel;
    next_pwm_period = pwm_period;
    next_pwm_clock_choice = pwm_clock_choice;
    next_ctrl = ctrl;
    table_we = 1'b0;
    burst_load = 1'b0;
    if (do_write) begin
      case (next_waddr)
        `OFS_START_DELAY: begin
          next_start_delay = merge(start_delay, next_wdata, next_wstrb);
        end
        `OFS_BURST_COUNT: begin
          burst_load = |next_wstrb[2:1];
        end
        `OFS_STEP_DIST: begin
          next_step_travel = merge(step_travel, next_wdata,
                                   next_wstrb); // R8
        end
        `OFS_TABLE_PORT: begin
          table_we = (wr_ptr != `TABLE_LAST); // R9
        end
        `OFS_CONTROL: begin
          if (next_wstrb[3]) begin
            next_ctrl.match_run = next_wdata[`RUN_BIT]; // R11
            next_ctrl.interp_clock_choice = next_wdata[`INTERP_BIT];
            next_ctrl.match_force_field =
              next_wdata[`FORCE_HI:`FORCE_LO]; // R16
            next_ctrl.match_pin_invert = next_wdata[`INVERT_BIT]; // R17
          end
        end
        `OFS_PWM_SETUP: begin
          wval = merge({pwm_period, 15'h0000, pwm_clock_choice},
                       next_wdata, next_wstrb);
          next_pwm_period = wval[`SETUP_PER_HI:`SETUP_PER_LO];
          next_pwm_clock_choice = wval[`SETUP_CHOICE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // comparison engine
  always_comb begin
    logic flush;
    flush = do_write && (next_waddr == `OFS_CONTROL) && next_wstrb[3] &&
            next_wdata[`FLUSH_BIT];
    next_wr_ptr = wr_ptr;
    next_cmp_ptr = cmp_ptr;
    next_position = position;
    next_match_state = match_state;
    next_check = 1'b0;
    if (table_we) begin
      next_wr_ptr = 12'(wr_ptr + `PTR_ONE); // R9
    end
    if (!ctrl.match_run) begin
      next_cmp_ptr = 12'h000;
      next_position = 32'h0000_0000;
    end else if (interp_edge) begin
      next_position = 32'(position + step_travel); // R18
      next_check = 1'b1;
    end else if (check && (cmp_ptr != wr_ptr) &&
                 (position >= table_entry_value)) begin
      next_match_state = ~match_state; // R18
      next_cmp_ptr = 12'(cmp_ptr + `PTR_ONE);
    end
    if (flush) begin
      next_wr_ptr = 12'h000; // R12
      next_cmp_ptr = 12'h000;
    end
  end

  // all registers of the top except MATCH_OUTPUT_PIN_O
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bresp <= `RESP_OKAY;
      bvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      start_delay <= 32'h0000_0000;
      step_travel <= 32'h0000_0000;
      pwm_period <= `PERIOD_RESET;
      pwm_clock_choice <= 1'b0;
      ctrl <= '0;
      wr_ptr <= 12'h000;
      cmp_ptr <= 12'h000;
      position <= 32'h0000_0000;
      match_state <= 1'b0;
      check <= 1'b0;
      phase_prev <= 1'b0;
      servo_prev <= 1'b0;
    end else if (CE_I) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rvalid <= next_rvalid;
      start_delay <= next_start_delay;
      step_travel <= next_step_travel;
      pwm_period <= next_pwm_period;
      pwm_clock_choice <= next_pwm_clock_choice;
      ctrl <= next_ctrl;
      wr_ptr <= next_wr_ptr;
      cmp_ptr <= next_cmp_ptr;
      position <= next_position;
      match_state <= next_match_state;
      check <= next_check;
      phase_prev <= PHASE_CLK_I;
      servo_prev <= SERVO_CLK_I;
    end
  end

  // forced level overrides the match state, then polarity
  assign compare_out = ctrl.match_force_field[0] ?
                       ctrl.match_force_field[1] : match_state; // R16
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      MATCH_OUTPUT_PIN_O <= 1'b0;
    end else if (CE_I) begin
      MATCH_OUTPUT_PIN_O <= compare_out ^ ctrl.match_pin_invert; // R17
    end
  end

  assign pwm_setup.pwm_lag_step = start_delay[`LAG_HI:`LAG_LO]; // R1
  assign pwm_setup.delay = start_delay[`DELAY_HI:`DELAY_LO];
  assign pwm_setup.period = pwm_period;

  pwm_burst_engine i_pwm_burst_engine (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .load_i(burst_load),
    .count_i(next_wdata[`COUNT_HI:`COUNT_LO]),
    .setup_i(pwm_setup),
    .clk_edge_i(pwm_edge),
    .remaining_o(burst_remaining),
    .pwm_o(PWM_O)
  );

  compare_table_mem i_compare_table_mem (
    .clk_i(MCLK_I),
    .ce_i(CE_I),
    .we_i(table_we),
    .waddr_i(wr_ptr),
    .wdata_i(next_wdata),
    .raddr_i(next_cmp_ptr),
    .rdata_o(table_entry_value)
  );
endmodule : pwm_burst_and_position_compare

/* File: verilog/pwm_burst_engine.sv */
// delayed, counted pwm burst generator
`timescale 1ns/1ps
`include "pwm_compare_cfg.svh"
module pwm_burst_engine
  import pwm_compare_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [11:0] count_i,
  input wire pwm_setup_t setup_i,
  input wire logic clk_edge_i,
  output logic [11:0] remaining_o,
  output logic pwm_o
);
  pwm_state_t state, next_state;
  logic [11:0] next_remaining;
  logic [13:0] unit_cnt, next_unit_cnt;
  logic [9:0] unit_num, next_unit_num;
  logic [15:0] per_cnt, next_per_cnt;
  logic next_pwm;
  logic [13:0] unit_len;

  // one lag unit is (lag step + 2) x 10 ns in clock cycles
  assign unit_len = 14'((14'(setup_i.pwm_lag_step) + `LAG_EXTRA) *
                        14'(`LAG_STEP_CYC)); // R1

  // burst sequencing
  always_comb begin
    next_state = state;
    next_remaining = remaining_o;
    next_unit_cnt = unit_cnt;
    next_unit_num = unit_num;
    next_per_cnt = per_cnt;
    case (state)
      PWM_IDLE: begin
      end
      PWM_ARM: begin
        if (clk_edge_i) begin // R2
          next_state = PWM_DELAY;
          next_unit_cnt = 14'h0000;
          next_unit_num = 10'h000;
        end
      end
      PWM_DELAY: begin
        if (unit_cnt == 14'(unit_len - 14'h0001)) begin
          next_unit_cnt = 14'h0000;
          next_unit_num = 10'(unit_num + 10'h001);
          // delay + 3 units in total
          if (unit_num == 10'(10'(setup_i.delay) + `DELAY_EXTRA)) begin // R2
            next_state = PWM_RUN;
            next_per_cnt = 16'h0000;
          end
        end else begin
          next_unit_cnt = 14'(unit_cnt + 14'h0001);
        end
      end
      PWM_RUN: begin
        if (per_cnt >= 16'(setup_i.period - 16'h0001)) begin
          next_per_cnt = 16'h0000;
          if (remaining_o != `COUNT_MAX) begin // R7
            next_remaining = 12'(remaining_o - 12'h001); // R5
            if (remaining_o == 12'h001) begin
              next_state = PWM_IDLE; // R6
            end
          end
        end else begin
          next_per_cnt = 16'(per_cnt + 16'h0001);
        end
      end
      default: begin
        next_state = PWM_IDLE;
      end
    endcase
    if (load_i) begin
      next_remaining = count_i;
      next_state = (count_i != 12'h000) ? PWM_ARM : PWM_IDLE; // R6
    end
    next_pwm = (next_state == PWM_RUN) &&
               (next_per_cnt < {1'b0, setup_i.period[15:1]});
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PWM_IDLE;
      remaining_o <= 12'h000;
      unit_cnt <= 14'h0000;
      unit_num <= 10'h000;
      per_cnt <= 16'h0000;
      pwm_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      remaining_o <= next_remaining;
      unit_cnt <= next_unit_cnt;
      unit_num <= next_unit_num;
      per_cnt <= next_per_cnt;
      pwm_o <= next_pwm;
    end
  end
endmodule : pwm_burst_engine

/* File: verilog/pwm_compare_cfg.svh */
// register map, field positions and timing constants
`ifndef PWM_COMPARE_CFG_SVH
`define PWM_COMPARE_CFG_SVH

`define ADDR_W 8
`define OFS_START_DELAY 8'h00
`define OFS_BURST_COUNT 8'h04
`define OFS_STEP_DIST 8'h08
`define OFS_TABLE_PORT 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_STATUS 8'h14
`define OFS_PWM_SETUP 8'h18

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define LAG_HI 31
`define LAG_LO 20
`define DELAY_HI 16
`define DELAY_LO 8
`define COUNT_HI 19
`define COUNT_LO 8
`define RUN_BIT 31
`define FLUSH_BIT 30
`define INTERP_BIT 29
`define FORCE_HI 27
`define FORCE_LO 26
`define INVERT_BIT 25
`define STAT_OUT_BIT 31
`define STAT_WP_HI 23
`define STAT_WP_LO 12
`define STAT_CP_HI 11
`define STAT_CP_LO 0
`define SETUP_CHOICE_BIT 0
`define SETUP_PER_HI 31
`define SETUP_PER_LO 16

`define COUNT_MAX 12'hFFF
`define TABLE_LAST 12'hFFF
`define PTR_ONE 12'h001
`define DELAY_EXTRA 10'h002
`define LAG_EXTRA 14'h0002
`define PERIOD_RESET 16'h0028

`define CLK_PERIOD_NS 5
`define LAG_STEP_NS 10
`define LAG_STEP_CYC ((`LAG_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verilog/pwm_compare_pkg.sv */
// shared types of the pulse burst and position compare block
package pwm_compare_pkg;

  typedef enum logic [3:0] {
    PWM_IDLE = 4'b0001,
    PWM_ARM = 4'b0010,
    PWM_DELAY = 4'b0100,
    PWM_RUN = 4'b1000
  } pwm_state_t;

  typedef struct packed {
    logic [11:0] pwm_lag_step;
    logic [8:0] delay;
    logic [15:0] period;
  } pwm_setup_t;

  typedef struct packed {
    logic match_run;
    logic interp_clock_choice;
    logic [1:0] match_force_field;
    logic match_pin_invert;
  } match_ctrl_t;

endpackage : pwm_compare_pkg
